//--- inc/gpt_pkg.sv
`default_nettype none
package gpt_pkg;
  // ==========================================================================
  // width configuration codes
  localparam logic [2:0]  CFG_TIMER32    = 3'h0;
  localparam logic [2:0]  CFG_RTC32      = 3'h1;
  localparam logic [2:0]  CFG_SPLIT16    = 3'h4;
  // ==========================================================================
  // per-timer mode field codes
  localparam logic [1:0]  MODE_ONE_SHOT  = 2'h1;
  localparam logic [1:0]  MODE_PERIODIC  = 2'h2;
  // ==========================================================================
  // values after reset and fixed load values
  localparam logic [15:0] LOAD_RESET     = 16'hFFFF;
  localparam logic [7:0]  PRESCALE_RESET = 8'h00;
  localparam logic [31:0] MATCH_RESET    = 32'hFFFF_FFFF;
  localparam logic [31:0] RTC_FIRST      = 32'h0000_0001;
  localparam logic [31:0] RTC_ROLL       = 32'h0000_0000;
  // ==========================================================================
  // flag bit positions
  localparam int          FLAG_W         = 3;
  localparam int          FLAG_A_TIMEOUT = 0;
  localparam int          FLAG_B_TIMEOUT = 1;
  localparam int          FLAG_RTC       = 2;
  // ==========================================================================
  // decoded width configuration
  typedef enum logic [1:0] {
    GPT_OFF,
    GPT_TIMER32,
    GPT_RTC32,
    GPT_SPLIT16
  } gpt_width_t;
endpackage : gpt_pkg
`default_nettype wire

//--- logic/gpt_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module gpt_prescale #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_run,
  input  wire logic         i_reload,
  input  wire logic [W-1:0] i_prescale,
  output logic              o_tick
);
  // ==========================================================================
  // divider: one tick every prescale+1 clocks
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  assign o_tick = i_run && (cnt == '0);

  always_comb
  begin
    next_cnt = cnt;
    if (i_reload)
    begin
      next_cnt = i_prescale;
    end
    else if (i_run)
    begin
      if (cnt == '0)
      begin
        next_cnt = i_prescale;
      end
      else
      begin
        next_cnt = cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end
endmodule : gpt_prescale
`default_nettype wire

//--- logic/gpt_timer_block.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - reset: idle, controls cleared, counters and loads 0xFFFF, prescales 0x00
// - config 0 is 32-bit one-shot/periodic, 1 is 32-bit RTC
// - config 0x4 runs A and B as independent 16-bit timers
// - 32-bit load write splits upper half to B, lower to A
// - 32-bit counter read gives B in upper half, A in lower
// - 32-bit timer counts down; only the A mode field picks one-shot/periodic
// - mode field 0x1 is one-shot, 0x2 is periodic
// - 32-bit timer counts down, reloads concatenated load the cycle after zero
// - one-shot stops and clears its enable; periodic keeps going
// - 32-bit zero sets sticky time-out flag, masked copy when mask set
// - 32-bit trigger pulse one cycle at zero when trigger enabled
// - load write while running takes effect the next cycle
// - stall bit freezes the timer until released
// - RTC counts up, loaded with 1 when the mode is first selected
// - RTC rolls to zero on match and keeps counting until disabled
// - RTC match sets sticky flag, masked copy and interrupt; clear bit clears
// - RTC counts the 32 KHz slow clock pin supplied from outside
// - stall bits do not freeze RTC while RTC enable set
// - 16-bit timers count down with optional 8-bit prescaler
// - 16-bit timer reloads load and prescale after zero; one-shot stops
// - 16-bit zero sets sticky flag, masked copy and interrupt
// - 16-bit trigger pulse one cycle at zero when trigger enabled
// - prescale p gives one decrement every p+1 clocks
module gpt_timer_block #(
  parameter int PRE_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [2:0]        i_width_config,
  input  wire logic [1:0]        i_a_mode_field,
  input  wire logic [1:0]        i_b_mode_field,
  input  wire logic              i_ctl_wr,
  input  wire logic              i_a_enable_bit,
  input  wire logic              i_b_enable_bit,
  input  wire logic              i_a_stall_bit,
  input  wire logic              i_b_stall_bit,
  input  wire logic              i_a_trigger_enable,
  input  wire logic              i_b_trigger_enable,
  input  wire logic              i_rtc_enable_bit,
  input  wire logic              i_a_load_wr,
  input  wire logic              i_b_load_wr,
  input  wire logic [31:0]       i_load_data,
  input  wire logic              i_a_prescale_wr,
  input  wire logic              i_b_prescale_wr,
  input  wire logic [PRE_W-1:0]  i_prescale_data,
  input  wire logic              i_match_wr,
  input  wire logic [31:0]       i_match_data,
  input  wire logic              i_clear_wr,
  input  wire logic [2:0]        i_clear_bits,
  input  wire logic [2:0]        i_flag_mask,
  input  wire logic              i_slow_clock_pin,
  output logic                   o_a_enable_bit,
  output logic                   o_b_enable_bit,
  output logic [31:0]            o_a_counter_value,
  output logic [15:0]            o_b_counter_value,
  output logic [15:0]            o_a_interval_load,
  output logic [15:0]            o_b_interval_load,
  output logic [PRE_W-1:0]       o_a_prescale,
  output logic [PRE_W-1:0]       o_b_prescale,
  output logic [2:0]             o_raw_flags,
  output logic [2:0]             o_masked_flags,
  output logic                   o_irq,
  output logic                   o_a_trigger,
  output logic                   o_b_trigger
);
  // ==========================================================================
  // state
  logic [15:0]       a_cnt, b_cnt, a_load, b_load;
  logic [PRE_W-1:0]  a_pre, b_pre;
  logic [31:0]       match;
  logic              a_en, b_en;
  logic [2:0]        raw;
  logic [2:0]        cfg_prev;
  logic              slow_s1, slow_s2, slow_s3;
  logic [15:0]       next_a_cnt, next_b_cnt, next_a_load, next_b_load;
  logic [PRE_W-1:0]  next_a_pre, next_b_pre;
  logic [31:0]       next_match;
  logic              next_a_en, next_b_en;
  logic [2:0]        next_raw;

  // ==========================================================================
  // decode
  gpt_pkg::gpt_width_t width;
  logic              a_mode_ok, b_mode_ok;
  logic              run32, run16a, run16b, run_a;
  logic [31:0]       cnt32;
  logic [PRE_W-1:0]  a_pre_eff;
  logic              tick_a, tick_b, hit_a, hit_b;
  logic              rtc_first, rtc_step, rtc_hit, slow_rise;
  logic [2:0]        flag_set;

  always_comb
  begin
    case (i_width_config)
      gpt_pkg::CFG_TIMER32: width = gpt_pkg::GPT_TIMER32;
      gpt_pkg::CFG_RTC32:   width = gpt_pkg::GPT_RTC32;
      gpt_pkg::CFG_SPLIT16: width = gpt_pkg::GPT_SPLIT16;
      default:              width = gpt_pkg::GPT_OFF;
    endcase
  end

  assign a_mode_ok = (i_a_mode_field == gpt_pkg::MODE_ONE_SHOT) || (i_a_mode_field == gpt_pkg::MODE_PERIODIC);
  assign b_mode_ok = (i_b_mode_field == gpt_pkg::MODE_ONE_SHOT) || (i_b_mode_field == gpt_pkg::MODE_PERIODIC);

  assign run32  = (width == gpt_pkg::GPT_TIMER32) && a_en && a_mode_ok;
  assign run16a = (width == gpt_pkg::GPT_SPLIT16) && a_en && a_mode_ok;
  assign run16b = (width == gpt_pkg::GPT_SPLIT16) && b_en && b_mode_ok;
  assign cnt32  = {b_cnt, a_cnt};
  assign run_a  = (run32 || run16a) && !i_a_stall_bit;
  // prescaler has no meaning for the 32-bit timer, so it steps every clock
  assign a_pre_eff = run16a ? a_pre : '0;

  // ==========================================================================
  // prescalers
  // optional prescaler
  gpt_prescale #(.W (PRE_W)) u_pre_a (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_run      (run_a),
    .i_reload   (i_ctl_wr || i_a_load_wr || i_a_prescale_wr),
    .i_prescale (a_pre_eff),
    .o_tick     (tick_a)
  );

  gpt_prescale #(.W (PRE_W)) u_pre_b (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_run      (run16b && !i_b_stall_bit),
    .i_reload   (i_ctl_wr || i_b_load_wr || i_b_prescale_wr),
    .i_prescale (b_pre),
    .o_tick     (tick_b)
  );

  assign hit_a = tick_a && (run32 ? (cnt32 == 32'h0000_0000) : (a_cnt == 16'h0000));
  assign hit_b = tick_b && (b_cnt == 16'h0000);

  // ==========================================================================
  // rtc
  // edge of synchronised pin
  assign slow_rise = slow_s2 && !slow_s3;
  assign rtc_first = (width == gpt_pkg::GPT_RTC32) && (cfg_prev != gpt_pkg::CFG_RTC32);
  assign rtc_step  = (width == gpt_pkg::GPT_RTC32) && a_en && slow_rise && !rtc_first
                     && !((i_a_stall_bit || i_b_stall_bit) && !i_rtc_enable_bit);
  assign rtc_hit   = rtc_step && (cnt32 == match);

  // ==========================================================================
  // next state
  always_comb
  begin
    next_a_cnt  = a_cnt;
    next_b_cnt  = b_cnt;
    next_a_load = a_load;
    next_b_load = b_load;
    next_a_pre  = i_a_prescale_wr ? i_prescale_data : a_pre;
    next_b_pre  = i_b_prescale_wr ? i_prescale_data : b_pre;
    next_match  = i_match_wr ? i_match_data : match;
    next_a_en   = a_en;
    next_b_en   = b_en;
    if (hit_a && (i_a_mode_field == gpt_pkg::MODE_ONE_SHOT))
    begin
      next_a_en = 1'b0;
    end
    if (hit_b && (i_b_mode_field == gpt_pkg::MODE_ONE_SHOT))
    begin
      next_b_en = 1'b0;
    end
    // software enable write wins over the self-clear
    if (i_ctl_wr)
    begin
      next_a_en = i_a_enable_bit;
      next_b_en = i_b_enable_bit;
    end
    if (rtc_first)
    begin
      {next_b_cnt, next_a_cnt} = gpt_pkg::RTC_FIRST;
    end
    else if (rtc_hit)
    begin
      {next_b_cnt, next_a_cnt} = gpt_pkg::RTC_ROLL;
    end
    else if (rtc_step)
    begin
      {next_b_cnt, next_a_cnt} = cnt32 + 32'h0000_0001;
    end
    else if (width == gpt_pkg::GPT_TIMER32)
    begin
      if (i_a_load_wr)
      begin
        {next_b_cnt, next_a_cnt} = i_load_data;
      end
      else if (hit_a)
      begin
        {next_b_cnt, next_a_cnt} = {b_load, a_load};
      end
      else if (tick_a)
      begin
        {next_b_cnt, next_a_cnt} = cnt32 - 32'h0000_0001;
      end
    end
    else if (width == gpt_pkg::GPT_SPLIT16)
    begin
      if (i_a_load_wr)
      begin
        next_a_cnt = i_load_data[15:0];
      end
      else if (hit_a)
      begin
        next_a_cnt = a_load;
      end
      else if (tick_a)
      begin
        next_a_cnt = a_cnt - 16'h0001;
      end
      if (i_b_load_wr)
      begin
        next_b_cnt = i_load_data[15:0];
      end
      else if (hit_b)
      begin
        next_b_cnt = b_load;
      end
      else if (tick_b)
      begin
        next_b_cnt = b_cnt - 16'h0001;
      end
    end
    if (i_a_load_wr)
    begin
      next_a_load = i_load_data[15:0];
      if ((width == gpt_pkg::GPT_TIMER32) || (width == gpt_pkg::GPT_RTC32))
      begin
        next_b_load = i_load_data[31:16];
      end
    end
    if (i_b_load_wr)
    begin
      next_b_load = i_load_data[15:0];
    end
  end

  // ==========================================================================
  // flags
  always_comb
  begin
    flag_set = '0;
    flag_set[gpt_pkg::FLAG_A_TIMEOUT] = hit_a;
    flag_set[gpt_pkg::FLAG_B_TIMEOUT] = hit_b;
    flag_set[gpt_pkg::FLAG_RTC]       = rtc_hit;
    next_raw = (raw & ~(i_clear_wr ? i_clear_bits : 3'h0)) | flag_set;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      a_cnt    <= gpt_pkg::LOAD_RESET;
      b_cnt    <= gpt_pkg::LOAD_RESET;
      a_load   <= gpt_pkg::LOAD_RESET;
      b_load   <= gpt_pkg::LOAD_RESET;
      a_pre    <= gpt_pkg::PRESCALE_RESET;
      b_pre    <= gpt_pkg::PRESCALE_RESET;
      match    <= gpt_pkg::MATCH_RESET;
      a_en     <= 1'b0;
      b_en     <= 1'b0;
      raw      <= '0;
      cfg_prev <= gpt_pkg::CFG_TIMER32;
      slow_s1  <= 1'b0;
      slow_s2  <= 1'b0;
      slow_s3  <= 1'b0;
    end
    else
    begin
      a_cnt    <= next_a_cnt;
      b_cnt    <= next_b_cnt;
      a_load   <= next_a_load;
      b_load   <= next_b_load;
      a_pre    <= next_a_pre;
      b_pre    <= next_b_pre;
      match    <= next_match;
      a_en     <= next_a_en;
      b_en     <= next_b_en;
      raw      <= next_raw;
      cfg_prev <= i_width_config;
      slow_s1  <= i_slow_clock_pin;
      slow_s2  <= slow_s1;
      slow_s3  <= slow_s2;
    end
  end

  // ==========================================================================
  // outputs
  // concatenated read
  assign o_a_counter_value = ((width == gpt_pkg::GPT_TIMER32) || (width == gpt_pkg::GPT_RTC32)) ?
                             cnt32 : {16'h0000, a_cnt};
  assign o_b_counter_value = b_cnt;
  assign o_a_interval_load = a_load;
  assign o_b_interval_load = b_load;
  assign o_a_prescale      = a_pre;
  assign o_b_prescale      = b_pre;
  assign o_a_enable_bit    = a_en;
  assign o_b_enable_bit    = b_en;
  assign o_raw_flags       = raw;
  assign o_masked_flags    = raw & i_flag_mask;
  assign o_irq             = |(raw & i_flag_mask);
  assign o_a_trigger       = hit_a && i_a_trigger_enable;
  assign o_b_trigger       = hit_b && i_b_trigger_enable;
endmodule : gpt_timer_block
`default_nettype wire

//--- verification/gpt_timer_block_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// port checker, one clock domain
module gpt_timer_block_checker (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [2:0]  i_width_config,
  input wire logic [1:0]  i_a_mode_field,
  input wire logic        i_ctl_wr,
  input wire logic        i_a_stall_bit,
  input wire logic        i_a_load_wr,
  input wire logic        i_b_load_wr,
  input wire logic        i_clear_wr,
  input wire logic [2:0]  i_clear_bits,
  input wire logic [2:0]  i_flag_mask,
  input wire logic        o_a_enable_bit,
  input wire logic [31:0] o_a_counter_value,
  input wire logic [15:0] o_a_interval_load,
  input wire logic [15:0] o_b_interval_load,
  input wire logic [2:0]  o_raw_flags,
  input wire logic [2:0]  o_masked_flags,
  input wire logic        o_irq,
  input wire logic        o_a_trigger,
  input wire logic        o_b_trigger
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic quiet;
  assign quiet = !i_a_load_wr && !i_b_load_wr && !i_ctl_wr;
  logic t32;
  assign t32 = (i_width_config == gpt_pkg::CFG_TIMER32);

  a_masked_copy:
    assert property (o_masked_flags == (o_raw_flags & i_flag_mask)) else $error("masked flags wrong");
  a_irq_level:
    assert property (o_irq == (|o_masked_flags)) else $error("irq not or of masked flags");
  a_trig_at_zero:
    assert property (o_a_trigger |-> o_a_counter_value[15:0] == 16'h0000) else $error("trigger off zero");
  a_trig_one_cycle:
    assert property (o_a_trigger |=> !o_a_trigger) else $error("trigger longer than one cycle");
  a_a_raw_set:
    assert property (o_a_trigger |=> o_raw_flags[0]) else $error("a time-out flag not set");
  a_b_raw_set:
    assert property (o_b_trigger |=> o_raw_flags[1]) else $error("b time-out flag not set");
  a_raw_sticky:
    assert property (o_raw_flags[0] && !(i_clear_wr && i_clear_bits[0]) |=> o_raw_flags[0])
      else $error("a flag dropped without clear");
  a_clear_next:
    assert property (i_clear_wr && i_clear_bits[0] && o_a_counter_value != 32'h0000_0000 |=> !o_raw_flags[0])
      else $error("clear did not act");
  a_stall_hold:
    assert property (t32 && i_a_stall_bit && quiet |=> $stable(o_a_counter_value)) else $error("stall did not freeze");
  a_oneshot_stop:
    assert property (o_a_trigger && t32 && i_a_mode_field == gpt_pkg::MODE_ONE_SHOT && !i_ctl_wr |=> !o_a_enable_bit)
      else $error("one-shot kept enable");
  a_reload_32:
    assert property (o_a_trigger && t32 && quiet && !i_a_stall_bit
      |=> o_a_counter_value == {o_b_interval_load, o_a_interval_load}) else $error("32-bit reload wrong");

  c_a_trigger: cover property (o_a_trigger);
  c_b_trigger: cover property (o_b_trigger);
  c_rtc_flag: cover property ($rose(o_raw_flags[2]));
endmodule : gpt_timer_block_checker

bind gpt_timer_block gpt_timer_block_checker u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_width_config(i_width_config), .i_a_mode_field(i_a_mode_field),
  .i_ctl_wr(i_ctl_wr), .i_a_stall_bit(i_a_stall_bit), .i_a_load_wr(i_a_load_wr), .i_b_load_wr(i_b_load_wr),
  .i_clear_wr(i_clear_wr), .i_clear_bits(i_clear_bits), .i_flag_mask(i_flag_mask),
  .o_a_enable_bit(o_a_enable_bit), .o_a_counter_value(o_a_counter_value),
  .o_a_interval_load(o_a_interval_load), .o_b_interval_load(o_b_interval_load), .o_raw_flags(o_raw_flags),
  .o_masked_flags(o_masked_flags), .o_irq(o_irq), .o_a_trigger(o_a_trigger), .o_b_trigger(o_b_trigger)
);
`default_nettype wire

//--- verification/gpt_timer_block_bench.sv
`timescale 1ns/100ps
`default_nettype none
module gpt_timer_block_bench;
  logic        i_clk, i_rst, i_ctl_wr, i_a_enable_bit, i_b_enable_bit, i_a_stall_bit, i_b_stall_bit;
  logic        i_a_trigger_enable, i_b_trigger_enable, i_rtc_enable_bit, i_a_load_wr, i_b_load_wr;
  logic        i_a_prescale_wr, i_b_prescale_wr, i_match_wr, i_clear_wr, i_slow_clock_pin;
  logic [2:0]  i_width_config, i_clear_bits, i_flag_mask, o_raw_flags, o_masked_flags;
  logic [1:0]  i_a_mode_field, i_b_mode_field;
  logic [31:0] i_load_data, i_match_data, o_a_counter_value, rng, ld, e;
  logic [7:0]  i_prescale_data, o_a_prescale, o_b_prescale, pv [4];
  logic [15:0] o_b_counter_value, o_a_interval_load, o_b_interval_load;
  logic        o_a_enable_bit, o_b_enable_bit, o_irq, o_a_trigger, o_b_trigger;
  int          err_count, checked, cycles, n;

  gpt_timer_block u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_width_config(i_width_config), .i_a_mode_field(i_a_mode_field),
    .i_b_mode_field(i_b_mode_field), .i_ctl_wr(i_ctl_wr), .i_a_enable_bit(i_a_enable_bit),
    .i_b_enable_bit(i_b_enable_bit), .i_a_stall_bit(i_a_stall_bit), .i_b_stall_bit(i_b_stall_bit),
    .i_a_trigger_enable(i_a_trigger_enable), .i_b_trigger_enable(i_b_trigger_enable),
    .i_rtc_enable_bit(i_rtc_enable_bit), .i_a_load_wr(i_a_load_wr), .i_b_load_wr(i_b_load_wr),
    .i_load_data(i_load_data), .i_a_prescale_wr(i_a_prescale_wr), .i_b_prescale_wr(i_b_prescale_wr),
    .i_prescale_data(i_prescale_data), .i_match_wr(i_match_wr), .i_match_data(i_match_data),
    .i_clear_wr(i_clear_wr), .i_clear_bits(i_clear_bits), .i_flag_mask(i_flag_mask),
    .i_slow_clock_pin(i_slow_clock_pin), .o_a_enable_bit(o_a_enable_bit), .o_b_enable_bit(o_b_enable_bit),
    .o_a_counter_value(o_a_counter_value), .o_b_counter_value(o_b_counter_value),
    .o_a_interval_load(o_a_interval_load), .o_b_interval_load(o_b_interval_load),
    .o_a_prescale(o_a_prescale), .o_b_prescale(o_b_prescale), .o_raw_flags(o_raw_flags),
    .o_masked_flags(o_masked_flags), .o_irq(o_irq), .o_a_trigger(o_a_trigger), .o_b_trigger(o_b_trigger)
  );

  initial begin i_clk = 0; forever #10 i_clk = ~i_clk; end
  // slow clock supplied
  // about 32 KHz, moved just after a clock edge like every other input
  initial begin
    i_slow_clock_pin = 0;
    forever begin repeat (781) @(posedge i_clk); #2 i_slow_clock_pin = ~i_slow_clock_pin; end
  end
  // ceiling well above the prescale and slow-clock waits
  always @(posedge i_clk) begin cycles++; if (cycles == 30000) begin err_count++; test_done(); end end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s;
  endfunction : xs
  function automatic logic [31:0] rtc_next(input logic [31:0] c, input logic [31:0] m);
    return (c == m) ? 32'h0000_0000 : c + 32'h0000_0001;
  endfunction : rtc_next
  task automatic tick(input int k); repeat (k) @(posedge i_clk); #2; endtask : tick
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin err_count++; $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen); end
  endtask : check
  task automatic load(input logic [31:0] d, input logic b);
    i_load_data = d; i_a_load_wr = !b; i_b_load_wr = b; tick(1); i_a_load_wr = 0; i_b_load_wr = 0;
  endtask : load
  task automatic ctl(input logic a, input logic b);
    i_a_enable_bit = a; i_b_enable_bit = b; i_ctl_wr = 1; tick(1); i_ctl_wr = 0;
  endtask : ctl
  task automatic clr(input logic [2:0] c); i_clear_bits = c; i_clear_wr = 1; tick(1); i_clear_wr = 0; endtask : clr
  task automatic wait_trig(input logic b, output int k);
    k = 0; while ((b ? o_b_trigger : o_a_trigger) !== 1'b1 && k < 3000) begin tick(1); k++; end
  endtask : wait_trig
  task automatic wait_step(output int k);
    logic [31:0] v;
    v = o_a_counter_value; k = 0;
    while (o_a_counter_value === v && k < 4000) begin tick(1); k++; end
  endtask : wait_step
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // ==========================================================================
  // main sequence
  initial begin
    {i_ctl_wr, i_a_enable_bit, i_b_enable_bit, i_a_stall_bit, i_b_stall_bit, i_a_trigger_enable} = '0;
    {i_b_trigger_enable, i_rtc_enable_bit, i_a_load_wr, i_b_load_wr, i_a_prescale_wr} = '0;
    {i_b_prescale_wr, i_match_wr, i_clear_wr, i_clear_bits, i_flag_mask, i_prescale_data} = '0;
    i_load_data = '0; i_match_data = '0; i_width_config = gpt_pkg::CFG_TIMER32;
    i_a_mode_field = 2'h0; i_b_mode_field = 2'h3; rng = 32'h0001_4E64; i_rst = 1;
    tick(8); i_rst = 0; tick(1);
    check("count", o_a_counter_value, 32'hFFFF_FFFF);
    check("loads", {o_b_interval_load, o_a_interval_load}, 32'hFFFF_FFFF);
    check("idle", {o_a_prescale, o_b_prescale, o_a_enable_bit, o_b_enable_bit, o_raw_flags, o_irq}, 0);
    rng = xs(rng); load(rng, 0);
    check("a_load", o_a_interval_load, rng[15:0]);
    check("b_load", o_b_interval_load, rng[31:16]);
    check("count32", o_a_counter_value, rng);
    // b mode left invalid on purpose: only the a field may matter
    rng = xs(rng); ld = 32'h0000_0003 + rng[4:0];
    i_a_mode_field = gpt_pkg::MODE_PERIODIC; i_a_trigger_enable = 1; i_flag_mask = 3'b001;
    load(ld, 0); ctl(1, 0); wait_trig(0, n); tick(1);
    check("raw_a", o_raw_flags[0], 1);
    check("irq", o_irq, 1);
    check("reload", o_a_counter_value, ld);
    wait_trig(0, n);
    check("period", n, ld);
    tick(2); load(32'h0000_0100, 0);
    check("live_load", o_a_counter_value, 32'h0000_0100);
    i_a_stall_bit = 1; tick(1); e = o_a_counter_value; tick(6);
    check("stalled", o_a_counter_value, e);
    i_a_stall_bit = 0; tick(2);
    check("resumed", o_a_counter_value, e - 2);
    clr(3'b001);
    check("cleared", o_raw_flags[0], 0);
    i_a_mode_field = gpt_pkg::MODE_ONE_SHOT; load(32'h0000_0005, 0); wait_trig(0, n); tick(1);
    check("oneshot_en", o_a_enable_bit, 0);
    tick(3);
    check("oneshot_held", o_a_counter_value, 32'h0000_0005);
    // split timers, prescale sweep incl. both ends
    ctl(0, 0); i_width_config = gpt_pkg::CFG_SPLIT16; i_a_mode_field = gpt_pkg::MODE_PERIODIC;
    rng = xs(rng); pv = '{8'h00, 8'h01, rng[7:0], 8'hFF};
    for (int i = 0; i < 4; i++) begin
      i_prescale_data = pv[i]; i_a_prescale_wr = 1; tick(1); i_a_prescale_wr = 0;
      check("pre_a", o_a_prescale, i_prescale_data);
      load(32'hABCD_00C8, 0); ctl(1, 0);
      check("upper_zero", o_a_counter_value[31:16], 0);
      wait_step(n); wait_step(n);
      check("pre_step", n, i_prescale_data + 1);
    end
    i_prescale_data = 8'h00; i_a_prescale_wr = 1; tick(1); i_a_prescale_wr = 0;
    load(ld, 0); ctl(1, 0); wait_trig(0, n); wait_trig(0, n); tick(1); wait_trig(0, n);
    check("period16", n, ld);
    rng = xs(rng); i_b_mode_field = gpt_pkg::MODE_ONE_SHOT; i_b_trigger_enable = 1;
    load(32'h0000_0004 + rng[3:0], 1); ctl(1, 1); wait_trig(1, n); tick(1);
    check("b_oneshot", o_b_enable_bit, 0);
    check("b_raw", o_raw_flags[1], 1);
    check("b_reload", o_b_counter_value, 16'h0004 + rng[3:0]);
    check("a_indep", o_a_enable_bit, 1);
    // real-time clock with stall bits set
    ctl(0, 0); i_width_config = gpt_pkg::CFG_RTC32; tick(1);
    check("rtc_first", o_a_counter_value, 32'h0000_0001);
    i_match_data = 32'h0000_0003; i_match_wr = 1; tick(1); i_match_wr = 0;
    i_flag_mask = 3'b100; i_rtc_enable_bit = 1; i_a_stall_bit = 1; i_b_stall_bit = 1; ctl(1, 0);
    e = 32'h0000_0001;
    repeat (4) begin
      wait_step(n); e = rtc_next(e, 32'h0000_0003);
      check("rtc_count", o_a_counter_value, e);
      if (e == 32'h0000_0000) begin
        tick(1);
        check("rtc_flag", {o_raw_flags[2], o_irq}, 2'b11);
        clr(3'b100);
        check("rtc_clear", o_raw_flags[2], 0);
      end
    end
    test_done();
  end
endmodule : gpt_timer_block_bench
`default_nettype wire
